// [cssel_top.sv]
// cssel_top: fuse decode, clock source select, reset and wake-up timeouts, rc trim load.
// assumes oscillator levels and fuse pins are asynchronous; power manager on core clock.
// Functional notes
// - four-bit source field picks crystal, low-frequency crystal, rc or external clock
// - a fuse bit at one is unprogrammed, at zero programmed
// - on wake count selected-source cycles and hold execution until done
// - on reset add a delay counted on the watchdog oscillator
// - reset timeout is 0, 4096 or 65536 watchdog cycles as fuses choose
// - default fuses give rc source, longest delay, divide by eight
// - crystal mode upper three bits select one of four frequency ranges
// - crystal wake count from bit0 and start-up bits: 258, 1K, 16K
// - crystal reset delay from same code: short, long or none
// - low-frequency codes 0110 and 0111 enable internal load capacitors
// - low-frequency start-up bits: none, short, long; 11 reserved
// - low-frequency bit0 picks 1K or 32K wake count
// - rc source nominal 8 MHz, divide by eight when fuse programmed
// - during reset load factory calibration byte into the rc trim register
// - reset timeout always runs from the watchdog oscillator, whatever source
// - rc mode wakes in 6 cycles, start-up bits choose reset delay
// - external clock mode wakes in 6 cycles, same reset delay choice
module cssel_top
  import cssel_pkg::*;
#(
  parameter int WAKE_16K_CYC = int'(CSSEL_WAKE_16K_CYC),
  parameter int WAKE_32K_CYC = int'(CSSEL_WAKE_32K_CYC),
  parameter int RST_LONG_CYC = int'(CSSEL_RST_LONG_CYC)
)(
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  // fuse pins and factory byte
  input  wire logic [CSSEL_SRC_W-1:0]     clock_source_select_fuses_i,
  input  wire logic [CSSEL_SUT_W-1:0]     startup_time_fuses_i,
  input  wire logic                       divide_by_eight_fuse_i,
  input  wire logic [CSSEL_TRIM_W-1:0]    factory_cal_i,
  // oscillator levels
  input  wire logic                       src_osc_i,
  input  wire logic                       watchdog_osc_i,
  // power manager
  input  wire logic                       sleep_req_i,
  input  wire logic                       wake_req_i,
  // register port
  input  wire logic [3:0]                 reg_addr_i,
  input  wire logic [31:0]                reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [31:0]                reg_rdata_o,
  // clock control outputs
  output cssel_src_e                      clk_src_o,
  output logic      [1:0]                 xtal_range_o,
  output logic                            load_cap_en_o,
  output logic                            div8_o,
  output logic      [CSSEL_TRIM_W-1:0]    rc_trim_register_o,
  output logic                            cpu_run_o,
  output logic                            reset_hold_o
);

  import cssel_pkg::*;

  // reset release
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pin synchronisers: first stage read only by the second
  localparam int PIN_W = CSSEL_FUSE_W + CSSEL_TRIM_W + 2;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [1:0]       osc_d;
  assign pin_raw = {factory_cal_i, divide_by_eight_fuse_i, startup_time_fuses_i,
                    clock_source_select_fuses_i, watchdog_osc_i, src_osc_i};

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      osc_d  <= '1;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      osc_d  <= pin_s2[1:0];
    end
  end

  logic src_tick;
  logic wdt_tick;
  assign src_tick = pin_s2[0] & ~osc_d[0];
  assign wdt_tick = pin_s2[1] & ~osc_d[1];

  // captured fuses: stored raw, 1 = unprogrammed
  logic [CSSEL_FUSE_W-1:0] fuse;
  logic [CSSEL_FUSE_W-1:0] next_fuse;
  logic [CSSEL_SRC_W-1:0]  cksrc;
  logic [CSSEL_SUT_W-1:0]  startup_time_fuses;
  logic [2:0]              xcode;
  assign cksrc = fuse[3:0];
  assign startup_time_fuses   = fuse[5:4];
  assign xcode = {cksrc[0], startup_time_fuses};

  // fuse decode
  cssel_src_e             src;
  logic [1:0]             range;
  logic                   cap_en;
  logic                   fallback;
  logic [CSSEL_CNT_W-1:0] wake_lim;
  logic [CSSEL_CNT_W-1:0] rst_lim;

  function automatic logic [CSSEL_CNT_W-1:0] sut_delay(input logic [1:0] s);
    logic [CSSEL_CNT_W-1:0] d;
    d = '0;
    if (s == CSSEL_SUT_SHORT)
      d = CSSEL_RST_SHORT_CYC;
    else if (s == CSSEL_SUT_LONG)
      d = CSSEL_CNT_W'(RST_LONG_CYC);
    return d;
  endfunction : sut_delay

  always_comb
  begin
    src      = CSSEL_SRC_RC;
    range    = 2'h0;
    cap_en   = 1'b0;
    fallback = 1'b0;
    wake_lim = CSSEL_WAKE_6_CYC;
    rst_lim  = CSSEL_CNT_W'(RST_LONG_CYC);
    if (cksrc[3])
    begin
      src   = CSSEL_SRC_XTAL;
      range = cksrc[2:1];
      if (xcode <= 3'h1)
        wake_lim = CSSEL_WAKE_258_CYC;
      else if (xcode <= 3'h4)
        wake_lim = CSSEL_WAKE_1K_CYC;
      else
        wake_lim = CSSEL_CNT_W'(WAKE_16K_CYC);
      case (xcode)
        3'h0, 3'h3, 3'h6: rst_lim = CSSEL_RST_SHORT_CYC;
        3'h1, 3'h4, 3'h7: rst_lim = CSSEL_CNT_W'(RST_LONG_CYC);
        default:          rst_lim = '0;
      endcase
    end
    else if (cksrc[2])
    begin
      if (startup_time_fuses == 2'h3)
        fallback = 1'b1;
      else
      begin
        src      = CSSEL_SRC_LFXTAL;
        cap_en   = cksrc[1];
        wake_lim = cksrc[0] ? CSSEL_CNT_W'(WAKE_32K_CYC) : CSSEL_WAKE_1K_CYC;
        rst_lim  = sut_delay(startup_time_fuses);
      end
    end
    else if (cksrc == CSSEL_CODE_RC || cksrc == CSSEL_CODE_EXT)
    begin
      if (startup_time_fuses == 2'h3)
        fallback = 1'b1;
      else
      begin
        src      = (cksrc == CSSEL_CODE_RC) ? CSSEL_SRC_RC : CSSEL_SRC_EXT;
        wake_lim = CSSEL_WAKE_6_CYC;
        rst_lim  = sut_delay(startup_time_fuses);
      end
    end
    else
      fallback = 1'b1;
  end

  // timeout counters: reset delay on watchdog osc, wake on selected source
  cssel_cnt_if rst_if ();
  cssel_cnt_if wake_if ();
  cssel_tick_counter u_rst_cnt (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .cnt_if  (rst_if.cnt)
  );
  cssel_tick_counter u_wake_cnt (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .cnt_if  (wake_if.cnt)
  );
  assign rst_if.tick   = wdt_tick;
  assign rst_if.limit  = rst_lim;
  assign wake_if.tick  = src_tick;
  assign wake_if.limit = wake_lim;

  // sequencer
  cssel_phase_e            phase;
  cssel_phase_e            next_phase;
  logic [1:0]              sync_cnt;
  logic [1:0]              next_sync_cnt;
  logic [CSSEL_TRIM_W-1:0] trim;
  logic [CSSEL_TRIM_W-1:0] next_trim;
  logic                    next_rst_start;
  logic                    next_wake_start;
  logic                    rst_start;
  logic                    wake_start;

  always_comb
  begin
    next_phase      = phase;
    next_sync_cnt   = sync_cnt;
    next_fuse       = fuse;
    next_trim       = trim;
    next_rst_start  = 1'b0;
    next_wake_start = 1'b0;
    case (phase)
      CSSEL_PH_SYNC:
      begin
        // wait for the pin pipeline to hold real fuse levels
        next_sync_cnt = sync_cnt + 2'h1;
        if (sync_cnt == CSSEL_SYNC_WAIT)
        begin
          next_fuse      = pin_s2[CSSEL_FUSE_W+1:2];
          next_trim      = pin_s2[PIN_W-1:CSSEL_FUSE_W+2];
          next_rst_start = 1'b1;
          next_phase     = CSSEL_PH_RST_DLY;
        end
      end
      CSSEL_PH_RST_DLY:
        if (rst_if.done)
          next_phase = CSSEL_PH_RUN;
      CSSEL_PH_RUN:
        if (sleep_req_i)
          next_phase = CSSEL_PH_SLEEP;
      CSSEL_PH_SLEEP:
        if (wake_req_i)
        begin
          next_wake_start = 1'b1;
          next_phase      = CSSEL_PH_WAKE;
        end
      CSSEL_PH_WAKE:
        if (wake_if.done)
          next_phase = CSSEL_PH_RUN;
      default:
        next_phase = CSSEL_PH_SYNC;
    endcase
    // software trim write, allowed in every phase after CSSEL_PH_SYNC
    if (reg_wr_i && reg_addr_i == CSSEL_ADDR_TRIM && phase != CSSEL_PH_SYNC)
      next_trim = reg_wdata_i[CSSEL_TRIM_W-1:0];
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase      <= CSSEL_PH_SYNC;
      sync_cnt   <= 2'h0;
      fuse       <= CSSEL_FUSE_RST;
      trim       <= CSSEL_TRIM_RST;
      rst_start  <= 1'b0;
      wake_start <= 1'b0;
    end
    else
    begin
      phase      <= next_phase;
      sync_cnt   <= next_sync_cnt;
      fuse       <= next_fuse;
      trim       <= next_trim;
      rst_start  <= next_rst_start;
      wake_start <= next_wake_start;
    end
  end

  assign rst_if.start  = rst_start;
  assign wake_if.start = wake_start;

  // register read port
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_i)
    begin
      if (reg_addr_i == CSSEL_ADDR_STATUS)
      begin
        next_rdata[CSSEL_ST_SRC +: 2]   = src;
        next_rdata[CSSEL_ST_RANGE +: 2] = range;
        next_rdata[CSSEL_ST_CAP]        = cap_en;
        next_rdata[CSSEL_ST_DIV8]       = div8_o;
        next_rdata[CSSEL_ST_FALLBACK]   = fallback;
        next_rdata[CSSEL_ST_RUN]        = cpu_run_o;
        next_rdata[CSSEL_ST_PHASE +: 3] = phase;
      end
      else if (reg_addr_i == CSSEL_ADDR_TRIM)
        next_rdata[CSSEL_TRIM_W-1:0] = trim;
      else if (reg_addr_i == CSSEL_ADDR_FUSE)
        next_rdata[CSSEL_FUSE_W-1:0] = fuse;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end

  // outputs; until capture the fuse register holds the shipped default
  assign reg_rdata_o        = rdata;
  assign clk_src_o          = src;
  assign xtal_range_o       = range;
  assign load_cap_en_o      = cap_en;
  assign div8_o             = (fuse[6] == CSSEL_PROGRAMMED);
  assign rc_trim_register_o = trim;
  assign cpu_run_o          = (phase == CSSEL_PH_RUN);
  assign reset_hold_o       = (phase == CSSEL_PH_SYNC) || (phase == CSSEL_PH_RST_DLY);

endmodule : cssel_top

// [cssel_pkg.sv]
// cssel_pkg: constants and types for the clock source and start-up select block.
// assumes a single 100 MHz core clock and fuse levels arriving as static pins.
package cssel_pkg;

  // fuse field widths and raw codes (a stored 1 is unprogrammed)
  localparam int          CSSEL_SRC_W      = 4;
  localparam int          CSSEL_SUT_W      = 2;
  localparam int          CSSEL_FUSE_W     = 7;
  localparam logic [3:0]  CSSEL_CODE_RC    = 4'h2;
  localparam logic [3:0]  CSSEL_CODE_EXT   = 4'h0;
  localparam logic [1:0]  CSSEL_SUT_NONE   = 2'h0;
  localparam logic [1:0]  CSSEL_SUT_SHORT  = 2'h1;
  localparam logic [1:0]  CSSEL_SUT_LONG   = 2'h2;
  localparam logic        CSSEL_PROGRAMMED = 1'b0;
  // shipped fuse state: rc source, longest start-up, divide by eight programmed
  localparam logic [6:0]  CSSEL_FUSE_RST   = 7'h22;

  // timeouts: nominal reset times, their watchdog-oscillator cycles, and wake counts in selected-source cycles
  localparam int          CSSEL_RST_SHORT_US  = 4100;
  localparam int          CSSEL_RST_LONG_US   = 65000;
  localparam int          CSSEL_CNT_W         = 17;
  localparam logic [16:0] CSSEL_RST_SHORT_CYC = 17'h01000;
  localparam logic [16:0] CSSEL_RST_LONG_CYC  = 17'h10000;
  localparam logic [16:0] CSSEL_WAKE_6_CYC    = 17'h00006;
  localparam logic [16:0] CSSEL_WAKE_258_CYC  = 17'h00102;
  localparam logic [16:0] CSSEL_WAKE_1K_CYC   = 17'h00400;
  localparam logic [16:0] CSSEL_WAKE_16K_CYC  = 17'h04000;
  localparam logic [16:0] CSSEL_WAKE_32K_CYC  = 17'h08000;
  localparam logic [1:0]  CSSEL_SYNC_WAIT     = 2'h3;

  // register map (byte addresses) and field positions
  localparam logic [3:0]  CSSEL_ADDR_STATUS = 4'h0;
  localparam logic [3:0]  CSSEL_ADDR_TRIM   = 4'h4;
  localparam logic [3:0]  CSSEL_ADDR_FUSE   = 4'h8;
  localparam int          CSSEL_ST_SRC      = 0;
  localparam int          CSSEL_ST_RANGE    = 2;
  localparam int          CSSEL_ST_CAP      = 4;
  localparam int          CSSEL_ST_DIV8     = 5;
  localparam int          CSSEL_ST_FALLBACK = 6;
  localparam int          CSSEL_ST_RUN      = 7;
  localparam int          CSSEL_ST_PHASE    = 8;
  localparam int          CSSEL_TRIM_W      = 7;
  localparam logic [6:0]  CSSEL_TRIM_RST    = 7'h00;

  typedef enum logic [1:0] {
    CSSEL_SRC_XTAL,
    CSSEL_SRC_LFXTAL,
    CSSEL_SRC_RC,
    CSSEL_SRC_EXT
  } cssel_src_e;

  typedef enum logic [2:0] {
    CSSEL_PH_SYNC,
    CSSEL_PH_RST_DLY,
    CSSEL_PH_RUN,
    CSSEL_PH_SLEEP,
    CSSEL_PH_WAKE
  } cssel_phase_e;

endpackage : cssel_pkg

// [cssel_cnt_if.sv]
// cssel_cnt_if: start, limit, tick and done between the sequencer and a timeout counter.
// assumes both ends share the core clock.
interface cssel_cnt_if;
  import cssel_pkg::*;
  logic                   start;
  logic [CSSEL_CNT_W-1:0] limit;
  logic                   tick;
  logic                   done;
  logic                   busy;

  modport ctrl (output start, output limit, output tick, input done, input busy);
  modport cnt  (input start, input limit, input tick, output done, output busy);
endinterface : cssel_cnt_if

// [cssel_tick_counter.sv]
// cssel_tick_counter: counts ticks of a slow oscillator down from a loaded limit.
// assumes tick is a one-cycle pulse already in the core clock domain.
module cssel_tick_counter
  import cssel_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control side
  cssel_cnt_if.cnt  cnt_if
);

  logic [CSSEL_CNT_W-1:0] cnt;
  logic [CSSEL_CNT_W-1:0] next_cnt;
  logic                   busy;
  logic                   next_busy;
  logic                   done;
  logic                   next_done;

  always_comb
  begin
    next_cnt  = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (cnt_if.start)
    begin
      // a zero limit means no delay: done on the next edge
      if (cnt_if.limit == '0)
      begin
        next_done = 1'b1;
        next_busy = 1'b0;
      end
      else
      begin
        next_cnt  = cnt_if.limit;
        next_busy = 1'b1;
      end
    end
    else if (busy && cnt_if.tick)
    begin
      next_cnt = cnt - 1'b1;
      if (cnt == {{(CSSEL_CNT_W-1){1'b0}}, 1'b1})
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign cnt_if.done = done;
  assign cnt_if.busy = busy;

endmodule : cssel_tick_counter

// [cssel_osc_model.sv]
// cssel_osc_model: source and watchdog oscillator levels seen by the block.
// assumes the core clock as time base; half periods in core cycles.
module cssel_osc_model
#(
  parameter int SRC_HALF = 2,
  parameter int WD_HALF  = 2
)(
  // time base
  input  wire logic clk_i,
  // oscillator levels
  output logic      src_osc_o,
  output logic      wdog_osc_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int sc = 0;
  int wc = 0;
  initial
  begin
    src_osc_o  = 1'b0;
    wdog_osc_o = 1'b0;
  end
  // watchdog keeps running whatever source is chosen
  always @(negedge clk_i)
  begin
    sc = (sc + 1) % SRC_HALF;
    wc = (wc + 1) % WD_HALF;
    if (sc == 0)
      src_osc_o = ~src_osc_o;
    if (wc == 0)
      wdog_osc_o = ~wdog_osc_o;
  end
endmodule : cssel_osc_model

// [cssel_top_chk.sv]
// cssel_top_chk: port checks for the clock select block.
// assumes bind into cssel_top; one core clock domain.
module cssel_top_chk
  import cssel_pkg::*;
(
  // clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  rst_n_i,
  // requests
  input wire logic [3:0]            reg_addr_i,
  input wire logic [31:0]           reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic                  sleep_req_i,
  input wire logic                  wake_req_i,
  // results
  input wire logic [31:0]           reg_rdata_o,
  input wire cssel_pkg::cssel_src_e clk_src_o,
  input wire logic [1:0]            xtal_range_o,
  input wire logic                  load_cap_en_o,
  input wire logic [6:0]            rc_trim_register_o,
  input wire logic                  cpu_run_o,
  input wire logic                  reset_hold_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [6:0] wd_lo;
  logic       trim_wr;
  assign wd_lo   = reg_wdata_i[6:0];
  assign trim_wr = reg_wr_i && reg_addr_i == CSSEL_ADDR_TRIM;

  chk_run_excl: assert property (cpu_run_o |-> !reset_hold_o)
    else $error("run while reset held");
  chk_hold_to_run: assert property ($fell(reset_hold_o) |-> cpu_run_o)
    else $error("hold ended without run");
  chk_sleep_stop: assert property (cpu_run_o && sleep_req_i |=> !cpu_run_o)
    else $error("sleep request ignored");
  chk_run_keep: assert property (cpu_run_o && !sleep_req_i |=> cpu_run_o)
    else $error("run dropped");
  chk_wake_waits: assert property ($rose(wake_req_i) && !cpu_run_o && !reset_hold_o |-> !cpu_run_o [*8])
    else $error("wake too early");
  chk_cap_lf: assert property (load_cap_en_o |-> clk_src_o == CSSEL_SRC_LFXTAL)
    else $error("caps outside low-frequency mode");
  chk_range_xtal: assert property (clk_src_o != CSSEL_SRC_XTAL |-> xtal_range_o == 2'h0)
    else $error("range outside crystal mode");
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data without read");
  chk_trim_read: assert property (reg_rd_i && reg_addr_i == CSSEL_ADDR_TRIM
    |=> reg_rdata_o == {25'h0, $past(rc_trim_register_o)})
    else $error("trim read wrong");
  chk_trim_write: assert property (!reset_hold_o && trim_wr |=> rc_trim_register_o == $past(wd_lo))
    else $error("trim write lost");
  chk_trim_keep: assert property (!reset_hold_o && !trim_wr |=> $stable(rc_trim_register_o))
    else $error("trim changed unasked");

  cover property ($rose(cpu_run_o) && !$past(reset_hold_o));
  cover property (load_cap_en_o && cpu_run_o);
  cover property (!reset_hold_o && trim_wr);
endmodule : cssel_top_chk

bind cssel_top cssel_top_chk u_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .sleep_req_i(sleep_req_i),
  .wake_req_i(wake_req_i),
  .reg_rdata_o(reg_rdata_o),
  .clk_src_o(clk_src_o),
  .xtal_range_o(xtal_range_o),
  .load_cap_en_o(load_cap_en_o),
  .rc_trim_register_o(rc_trim_register_o),
  .cpu_run_o(cpu_run_o),
  .reset_hold_o(reset_hold_o)
);

// [cssel_top_tb.sv]
// cssel_top_tb: fuse sets, reset, sleep and wake, register traffic, queued checks.
// assumes the oscillator model and bound checker; long counts shortened.
module cssel_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cssel_pkg::*;
  localparam int W16 = 20;
  localparam int W32 = 40;
  localparam int RL  = 50;
  typedef struct {
    cssel_src_e src;
    logic [1:0] rng;
    logic       cap;
    logic       div;
    logic       fb;
    int         nw;
    int         nr;
    bit         wake;
  } cssel_note_s;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic [6:0]  fuse       = 7'h7F;
  logic [6:0]  cal        = 7'h00;
  logic        sleep_req  = 1'b0;
  logic        wake_req   = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [31:0] lfsr       = 32'h751DBAC3;
  logic        src_osc, wd_osc, cap, div8, run, hold;
  logic        src_d = 1'b0, wd_d = 1'b0, run_d = 1'b0, rd_d = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  rng;
  logic [6:0]  trim;
  cssel_src_e  clk_src;
  int          errors = 0, n_compared = 0, cycles = 0, cnt_w = 0, cnt_s = 0;
  cssel_note_s note_q[$];
  cssel_note_s nt;
  logic [31:0] rd_q[$];
  // fuse sets as {div8, start-up, source}; one short reset delay only, it is slow
  logic [6:0]  cfgs [10] = '{7'h3F, 7'h08, 7'h2C, 7'h67, 7'h44, 7'h22, 7'h40, 7'h43, 7'h35, 7'h1B};

  cssel_top #(.WAKE_16K_CYC(W16), .WAKE_32K_CYC(W32), .RST_LONG_CYC(RL)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .clock_source_select_fuses_i(fuse[3:0]), .startup_time_fuses_i(fuse[5:4]),
    .divide_by_eight_fuse_i(fuse[6]), .factory_cal_i(cal),
    .src_osc_i(src_osc), .watchdog_osc_i(wd_osc),
    .sleep_req_i(sleep_req), .wake_req_i(wake_req),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .clk_src_o(clk_src), .xtal_range_o(rng), .load_cap_en_o(cap), .div8_o(div8),
    .rc_trim_register_o(trim), .cpu_run_o(run), .reset_hold_o(hold)
  );
  cssel_osc_model u_osc (.clk_i(core_clk_i), .src_osc_o(src_osc), .wdog_osc_o(wd_osc));

  always #5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  function automatic cssel_note_s decode(input logic [6:0] f);
    cssel_note_s r;
    logic [2:0]  c;
    c = {f[0], f[5:4]};
    r = '{CSSEL_SRC_RC, 2'h0, 1'b0, ~f[6], 1'b1, 6, RL, 1'b0};
    if (f[3])
    begin
      r = '{CSSEL_SRC_XTAL, f[2:1], 1'b0, ~f[6], 1'b0, 0, 0, 1'b0};
      r.nw = c < 2 ? 258 : (c < 5 ? 1024 : W16);
      r.nr = c inside {2, 5} ? 0 : (c inside {1, 4, 7} ? RL : 4096);
    end
    else if (f[5:4] != 2'h3 && (f[3:2] == 2'h1 || f[3:0] == 4'h2 || f[3:0] == 4'h0))
    begin
      r.fb = 1'b0;
      r.nr = f[5:4] == 2'h0 ? 0 : (f[5:4] == 2'h1 ? 4096 : RL);
      if (f[2])
      begin
        r.src = CSSEL_SRC_LFXTAL;
        r.cap = f[1];
        r.nw  = f[0] ? W32 : 1024;
      end
      else if (!f[1])
        r.src = CSSEL_SRC_EXT;
    end
    return r;
  endfunction : decode

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // sync latency lets a few extra raw edges pass before the block reacts
  task automatic check_cnt(input int got, input int exp);
    n_compared++;
    if (got < exp || got > exp + 4)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_cnt

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr    <= 1'b0;
    @(posedge core_clk_i);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd   <= 1'b0;
    @(posedge core_clk_i);
  endtask : reg_rd

  task automatic wait_run();
    while (run !== 1'b1)
      @(posedge core_clk_i);
  endtask : wait_run

  task automatic run_cfg(input logic [6:0] f);
    cssel_note_s e;
    e = decode(f);
    rst_n_i <= 1'b0;
    fuse    <= f;
    cal     <= lfsr[6:0];
    lfsr = nxt(lfsr);
    note_q.push_back(e);
    repeat (12) @(posedge core_clk_i);
    check({29'h0, clk_src, div8}, {29'h0, CSSEL_SRC_RC, 1'b1});
    rst_n_i <= 1'b1;
    wait_run();
    reg_rd(CSSEL_ADDR_FUSE, {25'h0, f});
    reg_rd(CSSEL_ADDR_TRIM, {25'h0, cal});
    reg_wr(CSSEL_ADDR_STATUS, lfsr);
    reg_rd(CSSEL_ADDR_STATUS, {21'h0, 3'h2, 1'b1, e.fb, e.div, e.cap, e.rng, e.src});
    reg_rd(4'hC, 32'h0);
    reg_wr(CSSEL_ADDR_TRIM, lfsr);
    reg_rd(CSSEL_ADDR_TRIM, {25'h0, lfsr[6:0]});
    lfsr = nxt(lfsr);
    sleep_req <= 1'b1;
    @(posedge core_clk_i);
    sleep_req <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    e.wake = 1'b1;
    note_q.push_back(e);
    wake_req <= 1'b1;
    @(posedge core_clk_i);
    wake_req <= 1'b0;
    wait_run();
  endtask : run_cfg

  always @(posedge core_clk_i)
  begin
    src_d <= src_osc;
    wd_d  <= wd_osc;
    run_d <= run;
    rd_d  <= rd;
    if (!rst_n_i)
      cnt_w = 0;
    else if (hold && wd_osc && !wd_d)
      cnt_w++;
    if (wake_req)
      cnt_s = 0;
    else if (src_osc && !src_d)
      cnt_s++;
    if (rd_d)
      check(rdata, rd_q.pop_front());
    if (run && !run_d && rst_n_i)
    begin
      nt = note_q.pop_front();
      check({26'h0, clk_src, rng, cap, div8}, {26'h0, nt.src, nt.rng, nt.cap, nt.div});
      check_cnt(nt.wake ? cnt_s : cnt_w, nt.wake ? nt.nw : nt.nr);
    end
  end

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge core_clk_i);
    foreach (cfgs[i])
      run_cfg(cfgs[i]);
    // let the watcher take the last wake note before closing
    repeat (2) @(posedge core_clk_i);
    check(note_q.size(), 0);
    check(rd_q.size(), 0);
    end_of_test();
  end
endmodule : cssel_top_tb
